/* design/pilot_scheme.sv */
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
module pilot_scheme
  import pilot_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        zone1_i,
  input  wire logic        phase_over_i,
  input  wire logic        ground_dist_i,
  input  wire logic        ground_doc_i,
  input  wire logic        ground_dist_block_i,
  input  wire logic        ground_doc_block_i,
  input  wire logic        zone4_reverse_i,
  input  wire logic        out_of_step_i,
  input  wire logic        fault_detect_i,
  input  wire logic        permissive_rx_input_i,
  input  wire logic        permissive_rx2_i,
  input  wire logic        breaker1_open_input_i,
  input  wire logic        breaker2_open_input_i,
  output logic             trip_o,
  output logic             key_o
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [1:0]  scheme_select;
    logic [1:0]  receiver_count;
    logic        two_breakers;
    logic [1:0]  ground_sel;
    logic [7:0]  coord_pu;
    logic [7:0]  coord_do;
    logic [7:0]  rev_pu;
    logic [7:0]  rev_do;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        trip;
    logic        key;
  } state_s;

  state_s q, d;

  // ************************************************************
  // scheme decode
  // ************************************************************
  logic underreach_permissive_mode;
  logic overreach_permissive_mode;
  logic overreach_reverse_block_mode;
  logic any_overreach_mode;
  logic two_rx;
  logic overreach_combine;
  logic block_src;
  logic rev_guard;
  logic overreach_path;
  logic rx_combined;
  logic comparer_gate;
  logic coord_out;
  logic line_open_and;
  logic keying_or;
  logic fault_detect_gate;
  logic direct_trip;

  assign underreach_permissive_mode   = q.scheme_select == SCHEME_UNDR;
  assign overreach_permissive_mode    = q.scheme_select == SCHEME_OVR;
  assign overreach_reverse_block_mode = q.scheme_select == SCHEME_OVR_BLK;
  assign any_overreach_mode = overreach_permissive_mode |
                              overreach_reverse_block_mode;
  assign two_rx = q.receiver_count == RCVR_TWO;

  // phase overreach always in; ground paths chosen by setting
  assign overreach_combine = phase_over_i |
                             (q.ground_sel[0] & ground_dist_i) |
                             (q.ground_sel[1] & ground_doc_i);

  // each ground type brings its own blocking path
  assign block_src = any_overreach_mode &
                     ((q.ground_sel[0] & ground_dist_block_i) |
                      (q.ground_sel[1] & ground_doc_block_i) |
                      (overreach_reverse_block_mode &
                       zone4_reverse_i));

  // ************************************************************
  // reversal guard and coordination timers
  // ************************************************************
  // guard stretches blocking so a reversal after parallel-line
  // clearing cannot reach the comparer
  pickup_dropout_timer u_reversal_guard_timer (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .in_i      (block_src),
    .pickup_i  (q.rev_pu),
    .dropout_i (q.rev_do),
    .out_o     (rev_guard)
  );

  assign overreach_path = overreach_combine & ~rev_guard;

  always_comb begin
    rx_combined = permissive_rx_input_i;
    if (two_rx && underreach_permissive_mode) begin
      rx_combined = permissive_rx_input_i | permissive_rx2_i;
    end else if (two_rx) begin
      rx_combined = permissive_rx_input_i & permissive_rx2_i;
    end
  end

  assign comparer_gate = (underreach_permissive_mode | any_overreach_mode)
                         & overreach_path & rx_combined
                         & ~out_of_step_i;

  pickup_dropout_timer u_trip_coord_timer (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .in_i      (comparer_gate),
    .pickup_i  (q.coord_pu),
    .dropout_i (q.coord_do),
    .out_o     (coord_out)
  );

  // ************************************************************
  // trip and keying
  // ************************************************************
  assign direct_trip = underreach_permissive_mode & zone1_i;

  assign fault_detect_gate = fault_detect_i &
                             (direct_trip | coord_out);

  assign line_open_and = q.two_breakers ?
                         (breaker1_open_input_i &
                          breaker2_open_input_i) :
                         breaker1_open_input_i;

  // open-end keying would overtrip an ORed three-terminal pair
  assign keying_or = direct_trip |
                     (any_overreach_mode & overreach_combine) |
                     ((underreach_permissive_mode | any_overreach_mode) &
                      line_open_and &
                      ~(underreach_permissive_mode & two_rx));

  // ************************************************************
  // register bus
  // ************************************************************
  logic        access;
  logic        mapped;
  logic [31:0] rd_mux;
  logic [31:0] status;

  assign access = psel_i & penable_i;
  assign mapped = paddr_i == CTRL_OFS || paddr_i == TIMERS_OFS ||
                  paddr_i == STATUS_OFS;

  always_comb begin
    status = 32'h0000_0000;
    status[ST_TRIP]  = q.trip;
    status[ST_KEY]   = q.key;
    status[ST_CMP]   = comparer_gate;
    status[ST_COORD] = coord_out;
    status[ST_REV]   = rev_guard;
    status[ST_OPEN]  = line_open_and;
    status[ST_RX]    = rx_combined;
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      CTRL_OFS: begin
        rd_mux[SCHEME_LSB +: 2] = q.scheme_select;
        rd_mux[RCVR_LSB +: 2]   = q.receiver_count;
        rd_mux[TWO_BRK_BIT]     = q.two_breakers;
        rd_mux[GSEL_LSB +: 2]   = q.ground_sel;
      end
      TIMERS_OFS: begin
        rd_mux = {q.rev_do, q.rev_pu, q.coord_do, q.coord_pu};
      end
      STATUS_OFS: begin
        rd_mux = status;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    d = q;
    // one wait state so every answer comes from a flip-flop
    d.pready  = access & ~q.pready;
    d.pslverr = access & ~q.pready & ~mapped;
    d.prdata  = (access & ~q.pready & ~pwrite_i) ? rd_mux : 32'h0;
    if (access && q.pready && pwrite_i) begin
      case (paddr_i)
        CTRL_OFS: begin
          d.scheme_select  = pwdata_i[SCHEME_LSB +: 2];
          d.receiver_count = pwdata_i[RCVR_LSB +: 2];
          d.two_breakers   = pwdata_i[TWO_BRK_BIT];
          d.ground_sel     = pwdata_i[GSEL_LSB +: 2];
        end
        TIMERS_OFS: begin
          d.coord_pu = pwdata_i[CPU_LSB +: 8];
          d.coord_do = pwdata_i[CDO_LSB +: 8];
          d.rev_pu   = pwdata_i[RPU_LSB +: 8];
          d.rev_do   = pwdata_i[RDO_LSB +: 8];
        end
        default: begin
          d.coord_pu = q.coord_pu;
        end
      endcase
    end
    d.trip = fault_detect_gate;
    d.key  = keying_or;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q                <= '0;
      q.scheme_select  <= SCHEME_RST;
      q.receiver_count <= RCVR_RST;
      q.two_breakers   <= TWO_BRK_RST;
      q.ground_sel     <= GSEL_RST;
      q.coord_pu       <= COORD_PU_RST;
      q.coord_do       <= COORD_DO_RST;
      q.rev_pu         <= REV_PU_RST;
      q.rev_do         <= REV_DO_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata_o  = q.prdata;
  assign pready_o  = q.pready;
  assign pslverr_o = q.pslverr;
  assign trip_o    = q.trip;
  assign key_o     = q.key;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_underreach_permissive_mode_one_rx;
    underreach_permissive_mode && two_rx && overreach_path &&
    !out_of_step_i && (permissive_rx_input_i ^ permissive_rx2_i);
  endsequence

  sequence s_pott_one_rx;
    any_overreach_mode && two_rx &&
    (permissive_rx_input_i ^ permissive_rx2_i);
  endsequence

  sequence s_coord_armed;
    !coord_out && $rose(comparer_gate) && q.coord_pu > 8'h01;
  endsequence

  a_trip_needs_fd: assert property (
    trip_o |-> $past(fault_detect_i))
    else $error("trip without fault detector");

  a_direct_trip: assert property (
    (underreach_permissive_mode && zone1_i && fault_detect_i)
      |=> trip_o)
    else $error("underreach zone did not trip");

  a_zone1_keys: assert property (
    (underreach_permissive_mode && zone1_i) |=> key_o)
    else $error("underreach zone did not key");

  a_rx_or_underreach_permissive_mode: assert property (
    s_underreach_permissive_mode_one_rx |-> comparer_gate)
    else $error("underreach receivers not ORed");

  a_rx_and_pott: assert property (
    s_pott_one_rx |-> !comparer_gate)
    else $error("overreach receivers not ANDed");

  a_oos_inhibit: assert property (
    out_of_step_i |-> !comparer_gate)
    else $error("comparer passed during out-of-step");

  a_bko_suppress: assert property (
    (underreach_permissive_mode && two_rx && !zone1_i)
      |=> !key_o)
    else $error("breaker keying not suppressed");

  a_open_keys: assert property (
    (any_overreach_mode && line_open_and) |=> key_o)
    else $error("open breaker did not key");

  a_pott_keys: assert property (
    (any_overreach_mode && overreach_combine) |=> key_o)
    else $error("overreach did not key");

  // a zone trip may still land in the window; only the pilot path counts
  a_glitch_ride: assert property (
    s_coord_armed |=> !coord_out ##1 (!trip_o || $past(direct_trip)))
    else $error("channel glitch reached trip");

  a_guard_blocks: assert property (
    rev_guard |-> !comparer_gate)
    else $error("comparer passed under reversal guard");

  a_coord_trips: assert property (
    (coord_out && fault_detect_i) |=> trip_o)
    else $error("coordination timer did not trip");

  a_off_no_key: assert property (
    (q.scheme_select == SCHEME_OFF) |=> !key_o)
    else $error("key raised with no scheme selected");

  a_reset_clear: assert property (
    $fell(srst_i) |-> (!trip_o && !key_o && !coord_out &&
                       !rev_guard))
    else $error("outputs not clear after reset");

endmodule // pilot_scheme

/* design/pilot_pkg.sv */
package pilot_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0]  CTRL_OFS   = 8'h00;
  localparam logic [7:0]  TIMERS_OFS = 8'h04;
  localparam logic [7:0]  STATUS_OFS = 8'h08;

  // ************************************************************
  // control fields
  // ************************************************************
  localparam int SCHEME_LSB   = 0;
  localparam int RCVR_LSB     = 2;
  localparam int TWO_BRK_BIT  = 4;
  localparam int GSEL_LSB     = 5;

  localparam logic [1:0] SCHEME_OFF     = 2'h0;
  localparam logic [1:0] SCHEME_OVR     = 2'h1;
  localparam logic [1:0] SCHEME_UNDR    = 2'h2;
  localparam logic [1:0] SCHEME_OVR_BLK = 2'h3;
  localparam logic [1:0] RCVR_TWO       = 2'h2;

  localparam logic [1:0] SCHEME_RST   = SCHEME_OFF;
  localparam logic [1:0] RCVR_RST     = 2'h1;
  localparam logic       TWO_BRK_RST  = 1'b0;
  localparam logic [1:0] GSEL_RST     = 2'h3;

  // ************************************************************
  // timer fields, counted in sample periods
  // ************************************************************
  localparam int CPU_LSB = 0;
  localparam int CDO_LSB = 8;
  localparam int RPU_LSB = 16;
  localparam int RDO_LSB = 24;

  localparam logic [7:0] COORD_PU_RST = 8'h04;
  localparam logic [7:0] COORD_DO_RST = 8'h01;
  localparam logic [7:0] REV_PU_RST   = 8'h02;
  localparam logic [7:0] REV_DO_RST   = 8'h10;

  // ************************************************************
  // status fields
  // ************************************************************
  localparam int ST_TRIP  = 0;
  localparam int ST_KEY   = 1;
  localparam int ST_CMP   = 2;
  localparam int ST_COORD = 3;
  localparam int ST_REV   = 4;
  localparam int ST_OPEN  = 5;
  localparam int ST_RX    = 6;

endpackage

/* design/pickup_dropout_timer.sv */
`timescale 1ns/100ps
module pickup_dropout_timer (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       in_i,
  input  wire logic [7:0] pickup_i,
  input  wire logic [7:0] dropout_i,
  output logic            out_o
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       out;
  } tmr_s;

  tmr_s q, d;
  logic [8:0] nxt;

  always_comb begin
    d   = q;
    nxt = {1'b0, q.cnt} + 9'h001;
    if (q.out == (in_i)) begin
      d.cnt = 8'h00;
    end else if (nxt >= {1'b0, (q.out ? dropout_i : pickup_i)}) begin
      d.out = in_i;
      d.cnt = 8'h00;
    end else begin
      d.cnt = nxt[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign out_o = q.out;

  // ************************************************************
  // checks
  // ************************************************************
  a_timer_no_early: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (!q.out && $rose(in_i) && pickup_i > 8'h01) |=> !q.out)
    else $error("timer picked up before pickup delay");

endmodule // pickup_dropout_timer

/* dv/remote_terminal.sv */
`timescale 1ns/100ps
// ************************************************************
// far line end seen through the permissive channel
// ************************************************************
module remote_terminal #(
  parameter int LAT = 3
) (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic key_i,
  input  wire logic echo_i,
  input  wire logic perm_i,
  output logic      rx_o
);
  logic [LAT-1:0] pipe_q;

  // channel delay; an echo only follows our own key
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pipe_q <= '0;
    end else begin
      pipe_q <= {pipe_q[LAT-2:0], key_i};
    end
  end

  // perm_i: far end sends permission on its own fault view
  assign rx_o = (echo_i & pipe_q[LAT-1]) | perm_i;
endmodule // remote_terminal

/* dv/permissive_transfer_trip_logic_tb.sv */
`timescale 1ns/100ps
module permissive_transfer_trip_logic_tb;
  import pilot_pkg::*;
  typedef struct packed {
    logic z1, ph, gd, gdoc, gdb, gdocb, z4, oos, fd, rx2, b1, b2;
    logic echo, perm;
  } stim_s;
  localparam int          PU  = 6;
  localparam logic [31:0] TIM = 32'h1002_0106;
  logic        clk_i  = 1'b0;
  logic        srst_i = 1'b1;
  logic        psel   = 1'b0;
  logic        pen    = 1'b0;
  logic        pwr    = 1'b0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwd    = 32'h0;
  logic [31:0] prd;
  logic [31:0] rd;
  logic        prdy;
  logic        perr;
  logic        e;
  logic        trip;
  logic        key;
  logic        rx;
  stim_s       st     = '0;
  int          err_total   = 0;
  int          checks_done = 0;
  int          cycles      = 0;

  always #2.5 clk_i = ~clk_i;

  pilot_scheme dut (
    .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(perr), .zone1_i(st.z1),
    .phase_over_i(st.ph), .ground_dist_i(st.gd), .ground_doc_i(st.gdoc),
    .ground_dist_block_i(st.gdb), .ground_doc_block_i(st.gdocb),
    .zone4_reverse_i(st.z4), .out_of_step_i(st.oos),
    .fault_detect_i(st.fd), .permissive_rx_input_i(rx),
    .permissive_rx2_i(st.rx2), .breaker1_open_input_i(st.b1),
    .breaker2_open_input_i(st.b2), .trip_o(trip), .key_o(key)
  );

  remote_terminal far_end (
    .clk_i(clk_i), .srst_i(srst_i), .key_i(key), .echo_i(st.echo),
    .perm_i(st.perm), .rx_o(rx)
  );

  // ************************************************************
  // common tasks
  // ************************************************************
  task automatic close_out();
    $display("mismatches %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // hang guard, well above the thousand or so cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      close_out();
    end
  end

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      $display("wrong value %s expected %h seen %h", n, x, g);
      err_total++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    // no answer time assumed; only the hang guard ends this wait
    do begin
      @(posedge clk_i);
    end while (prdy !== 1'b1);
    rd = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic cfg(logic [1:0] s, logic [1:0] r, logic t, logic [1:0] g);
    apb(1'b1, CTRL_OFS, {25'h0, g, t, r, s});
  endtask

  task automatic clr();
    @(posedge clk_i);
    st <= '0;
    repeat (24) @(posedge clk_i);
  endtask

  task automatic no_trip(int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk_i);
      #1;
      seen |= trip;
    end
    chk("trip held off", 32'h0, 32'(seen));
  endtask

  task automatic wait_trip(int n);
    int i;
    i = 0;
    while (trip !== 1'b1 && i < n) begin
      @(posedge clk_i);
      #1;
      i++;
    end
    chk("trip", 32'h1, 32'(trip));
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic regs_test();
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", {25'h0, GSEL_RST, TWO_BRK_RST, RCVR_RST, SCHEME_RST}, rd);
    apb(1'b0, TIMERS_OFS, 32'h0);
    chk("timers", {REV_DO_RST, REV_PU_RST, COORD_DO_RST, COORD_PU_RST}, rd);
    apb(1'b1, TIMERS_OFS, TIM);
    apb(1'b0, TIMERS_OFS, 32'h0);
    chk("timers wr", TIM, rd);
    chk("no slverr", 32'h0, 32'(e));
    apb(1'b1, 8'h0c, 32'hffff_ffff);
    chk("slverr wr", 32'h1, 32'(e));
    apb(1'b0, 8'h0c, 32'h0);
    chk("slverr rd data", 32'h0, rd);
    chk("slverr rd", 32'h1, 32'(e));
    apb(1'b1, STATUS_OFS, 32'hffff_ffff);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status ro", 32'h0, rd);
  endtask

  task automatic pott_timing();
    cfg(SCHEME_OVR, RCVR_RST, 1'b0, 2'h3);
    @(posedge clk_i);
    st.ph <= 1'b1;
    st.perm <= 1'b1;
    st.fd <= 1'b1;
    repeat (PU) begin
      @(posedge clk_i);
      #1;
      chk("key", 32'h1, 32'(key));
      chk("trip early", 32'h0, 32'(trip));
    end
    @(posedge clk_i);
    #1;
    chk("trip at pickup", 32'h1, 32'(trip));
    @(posedge clk_i);
    st.fd <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("trip no fd", 32'h0, 32'(trip));
    clr();
  endtask

  task automatic glitch_and_oos();
    cfg(SCHEME_OVR, RCVR_RST, 1'b0, 2'h3);
    @(posedge clk_i);
    st.ph <= 1'b1;
    st.fd <= 1'b1;
    st.perm <= 1'b1;
    repeat (PU - 1) @(posedge clk_i);
    st.perm <= 1'b0;
    no_trip(12);
    @(posedge clk_i);
    st.oos <= 1'b1;
    st.perm <= 1'b1;
    no_trip(12);
    @(posedge clk_i);
    st.oos <= 1'b0;
    wait_trip(PU + 3);
    clr();
  endtask

  task automatic echo_trip();
    cfg(SCHEME_OVR_BLK, RCVR_RST, 1'b0, 2'h3);
    @(posedge clk_i);
    st.echo <= 1'b1;
    st.ph <= 1'b1;
    st.fd <= 1'b1;
    wait_trip(PU + 10);
    clr();
  endtask

  task automatic zone1_test();
    cfg(SCHEME_UNDR, RCVR_RST, 1'b0, 2'h3);
    @(posedge clk_i);
    st.z1 <= 1'b1;
    @(posedge clk_i);
    #1;
    chk("zone1 key", 32'h1, 32'(key));
    no_trip(4);
    @(posedge clk_i);
    st.fd <= 1'b1;
    @(posedge clk_i);
    #1;
    chk("zone1 trip", 32'h1, 32'(trip));
    clr();
  endtask

  task automatic rcvr_test();
    logic [1:0] m;
    for (int i = 0; i < 6; i++) begin
      m = (i < 3) ? SCHEME_UNDR : SCHEME_OVR;
      cfg(m, RCVR_TWO, 1'b0, 2'h3);
      @(posedge clk_i);
      st.perm <= (i % 3) != 1;
      st.rx2 <= (i % 3) != 0;
      st.ph <= 1'b1;
      st.fd <= 1'b1;
      repeat (PU + 3) @(posedge clk_i);
      #1;
      chk("rx combine", 32'((i < 3) || (i % 3 == 2)), 32'(trip));
      clr();
    end
  endtask

  task automatic brk(logic [1:0] s, logic [1:0] r, logic t, logic b2,
                     logic x);
    cfg(s, r, t, 2'h3);
    @(posedge clk_i);
    st.b1 <= 1'b1;
    st.b2 <= b2;
    repeat (2) @(posedge clk_i);
    #1;
    chk("breaker key", 32'(x), 32'(key));
    clr();
  endtask

  task automatic gsel_test();
    for (int g = 0; g < 4; g++) begin
      cfg(SCHEME_OVR, RCVR_RST, 1'b0, 2'(g));
      @(posedge clk_i);
      st.gd <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      chk("ground dist key", 32'(g & 1), 32'(key));
      @(posedge clk_i);
      st.gd <= 1'b0;
      st.gdoc <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      chk("ground doc key", 32'(g >> 1), 32'(key));
      clr();
    end
  endtask

  task automatic rev_case(logic [1:0] s);
    cfg(s, RCVR_RST, 1'b0, 2'h3);
    @(posedge clk_i);
    st.gdb <= (s == SCHEME_OVR);
    st.z4 <= (s == SCHEME_OVR_BLK);
    repeat (4) @(posedge clk_i);
    st.gdb <= 1'b0;
    st.z4 <= 1'b0;
    st.ph <= 1'b1;
    st.perm <= 1'b1;
    st.fd <= 1'b1;
    no_trip(10);
    wait_trip(30);
    // trip, key, comparer, coordination and receive bits all up
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status trip", 32'h0000_004f, rd);
  endtask

  task automatic reset_test();
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk("trip reset", 32'h0, 32'(trip));
    chk("key reset", 32'h0, 32'(key));
    @(posedge clk_i);
    srst_i <= 1'b0;
    st <= '0;
    apb(1'b0, TIMERS_OFS, 32'h0);
    chk("timers reset", {REV_DO_RST, REV_PU_RST, COORD_DO_RST,
        COORD_PU_RST}, rd);
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    regs_test();
    pott_timing();
    glitch_and_oos();
    echo_trip();
    zone1_test();
    rcvr_test();
    brk(SCHEME_OVR, RCVR_RST, 1'b0, 1'b0, 1'b1);
    brk(SCHEME_OVR, RCVR_RST, 1'b1, 1'b0, 1'b0);
    brk(SCHEME_OVR, RCVR_RST, 1'b1, 1'b1, 1'b1);
    brk(SCHEME_UNDR, RCVR_TWO, 1'b0, 1'b0, 1'b0);
    brk(SCHEME_UNDR, RCVR_RST, 1'b0, 1'b0, 1'b1);
    brk(SCHEME_OFF, RCVR_RST, 1'b0, 1'b0, 1'b0);
    gsel_test();
    rev_case(SCHEME_OVR);
    clr();
    rev_case(SCHEME_OVR_BLK);
    reset_test();
    close_out();
  end
endmodule // permissive_transfer_trip_logic_tb
